// ### mem_model.sv
// Word memory that stands in for the host's descriptor and buffer space.
module mem_model (
	input  wire logic        clk,   // Clock.
	input  wire logic        req,   // Request, held until ack.
	input  wire logic        we,    // Write when high.
	input  wire logic [31:0] addr,  // Byte address.
	input  wire logic [3:0]  be,    // Byte enables.
	input  wire logic [31:0] wdata, // Write data.
	output logic [31:0]      rdata, // Read data, valid with ack.
	output logic             ack    // Completion pulse.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] m [0:1023];
	int          w  = 0;
	int          sd = 32'h5a17;

	initial begin
		ack = 1'h0;
		rdata = 32'h0;
	end

	// four-word descriptors
	// Read data toggles while idle, so a stale capture shows up as wrong data.
	always @(posedge clk) begin
		ack <= 1'h0;
		rdata <= ~rdata;
		if (req && !ack && w > 0) begin
			w <= w - 1;
		end else if (req && !ack) begin
			ack <= 1'h1;
			w <= {$random(sd)} % 4;
			for (int b = 0; b < 4; b++) begin
				if (we && be[b]) begin
					m[addr[11:2]][8*b+:8] <= wdata[8*b+:8];
				end
			end
			if (!we) begin
				rdata <= m[addr[11:2]];
			end
		end
	end
endmodule

// ### rx_desc_checker.sv
// Concurrent checks on the memory and stream ports of the receive descriptor walker.
module rx_desc_checker (
	input wire logic        hclk,      // Clock.
	input wire logic        hresetn,   // Reset, active low.
	input wire logic        mem_req,   // Memory request.
	input wire logic        mem_we,    // Memory write.
	input wire logic [31:0] mem_addr,  // Memory address.
	input wire logic [3:0]  mem_be,    // Byte enables.
	input wire logic [31:0] mem_wdata, // Write data.
	input wire logic        mem_ack,   // Memory completion.
	input wire logic        rx_valid,  // Byte offered.
	input wire logic        rx_ready   // Byte taken.
);
	import rx_desc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire word_wr = mem_req && mem_we && mem_be == BE_WORD;

	sequence flags_wr;
		word_wr && mem_addr[3:0] == 4'hc;
	endsequence
	sequence release_wr;
		flags_wr ##0 !mem_wdata[FLAG_OWN] && !mem_wdata[FLAG_TDOWN];
	endsequence
	sequence byte_wr;
		mem_req && mem_we && mem_be != BE_WORD;
	endsequence

	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_wdata) && $stable(mem_we)) else $error("request moved before ack");
	no_link_wr_a: assert property (word_wr |-> mem_addr[3])
		else $error("word write to link or buffer word");
	word_align_a: assert property (mem_req && mem_be == BE_WORD |-> mem_addr[1:0] == 2'h0)
		else $error("unaligned word access");
	byte_lane_a: assert property (byte_wr |-> $onehot(mem_be)
		&& mem_wdata == {4{mem_wdata[7:0]}}) else $error("bad byte lane write");
	own_first_a: assert property (release_wr |-> mem_wdata[FLAG_FIRST])
		else $error("hardware_owns_flag cleared on a non-first descriptor");
	qend_last_a: assert property (flags_wr ##0 mem_wdata[FLAG_QEND] |-> mem_wdata[FLAG_LAST])
		else $error("queue end without last fragment");
	// Drained bytes raise no request, so only bytes followed by a request are checked.
	byte_store_a: assert property (rx_valid && rx_ready ##1 mem_req |-> byte_wr)
		else $error("accepted byte never stored");
	release_end_a: assert property (release_wr ##0 mem_ack |=> !word_wr [*4])
		else $error("write-back after hardware_owns_flag release");
endmodule

bind rx_descriptor_queue_handler rx_desc_checker u_chk (
	.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
	.mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .rx_valid(rx_valid),
	.rx_ready(rx_ready)
);

// ### rx_desc_pkg.sv
// Constants, field layouts and state codes for the receive descriptor queue handler.
package rx_desc_pkg;

	// Descriptor word offsets within the 16-byte structure.
	localparam logic [31:0] DESC_LINK  = 32'h0000_0000;
	localparam logic [31:0] DESC_BUF   = 32'h0000_0004;
	localparam logic [31:0] DESC_LEN   = 32'h0000_0008;
	localparam logic [31:0] DESC_FLAGS = 32'h0000_000c;
	localparam logic [31:0] NULL_LINK  = 32'h0000_0000;

	// Word 2 holds offset in the upper half and buffer length in the lower half.
	// Word 3 holds the flags in the upper half and packet length in the lower half.
	localparam int FLAG_FIRST     = 31;
	localparam int FLAG_LAST      = 30;
	localparam int FLAG_OWN       = 29;
	localparam int FLAG_QEND      = 28;
	localparam int FLAG_TDOWN     = 27;
	localparam int FLAG_CRC_KEPT  = 26;
	localparam int FLAG_JABBER    = 25;

	// Register byte addresses (low eight address bits).
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_HEAD   = 8'h04;
	localparam logic [7:0] REG_OFFSET = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_CUR    = 8'h10;

	// Control bits.
	localparam int CTRL_START    = 0;
	localparam int CTRL_TEARDOWN = 1;
	localparam int CTRL_KEEP_ERR = 2;

	// Status bits.
	localparam int ST_RUNNING    = 0;
	localparam int ST_QEND       = 1;
	localparam int ST_TDOWN_DONE = 2;

	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] ONE16  = 16'h0001;
	localparam logic [1:0]  HRESP_OKAY = 2'h0;
	localparam logic [3:0]  BE_WORD = 4'hf;
	localparam logic [3:0]  BE_BYTE0 = 4'h1;

	typedef enum logic [11:0] {
		ST_IDLE     = 12'h001,
		ST_RD_BUF   = 12'h002,
		ST_RD_LEN   = 12'h004,
		ST_WAIT     = 12'h008,
		ST_WR_BYTE  = 12'h010,
		ST_WB_LEN   = 12'h020,
		ST_RD_NEXT  = 12'h040,
		ST_WB_FLAGS = 12'h080,
		ST_WB_FIRST = 12'h100,
		ST_DRAIN    = 12'h200,
		ST_TEARDOWN = 12'h400,
		ST_HALTED   = 12'h800
	} state_t;

endpackage

// ### rx_descriptor_queue_handler.sv
// Receive descriptor walker: fills buffers from the receive stream and writes status back.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
module rx_descriptor_queue_handler (
	input  wire logic        hclk,           // Bus and core clock.
	input  wire logic        hresetn,        // Asynchronous reset, active low.
	input  wire logic        ce,             // Clock enable; all state holds while low.
	input  wire logic        hsel,           // Slave select.
	input  wire logic [31:0] haddr,          // Byte address.
	input  wire logic [1:0]  htrans,         // Transfer type.
	input  wire logic        hwrite,         // Write when high.
	input  wire logic [2:0]  hsize,          // Transfer size, word only.
	input  wire logic [31:0] hwdata,         // Write data.
	input  wire logic        hready,         // Bus ready.
	output logic             hreadyout,      // Slave ready, always high.
	output logic [1:0]       hresp,          // Always OKAY.
	output logic [31:0]      hrdata,         // Read data.
	output logic             mem_req,        // Memory request, held until ack.
	output logic             mem_we,         // Memory write when high.
	output logic [31:0]      mem_addr,       // Memory byte address.
	output logic [3:0]       mem_be,         // Byte enables.
	output logic [31:0]      mem_wdata,      // Memory write data.
	input  wire logic [31:0] mem_rdata,      // Memory read data, valid with ack.
	input  wire logic        mem_ack,        // Memory completes request.
	input  wire logic        rx_valid,       // Receive byte valid.
	input  wire logic [7:0]  rx_data,        // Receive byte.
	input  wire logic        rx_last,        // Final byte of packet.
	input  wire logic        rx_jabber,      // Packet is a jabber frame.
	input  wire logic        rx_crc_present, // Packet data carries its CRC.
	output logic             rx_ready        // Byte accepted when high with valid.
);
	import rx_desc_pkg::*;

	state_t      state;
	state_t      next_state;
	logic [31:0] head;
	logic [31:0] cur;
	logic [31:0] first_addr;
	logic [31:0] link;
	logic [31:0] buf_ptr;
	logic [15:0] buf_len;
	logic [15:0] count;
	logic [15:0] pkt_len;
	logic [15:0] offset_setting;
	logic [7:0]  byte_q;
	logic        is_first;
	logic        last_seen;
	logic        keep_err;
	logic        qend;
	logic        tdown_done;
	logic        tdown_req;
	logic        crc_kept;
	logic        jabber;
	logic [7:0]  a_addr;
	logic        a_wr;

	function automatic logic [31:0] flag_word(input logic first, input logic last,
			input logic own, input logic qe, input logic crc, input logic jab,
			input logic [15:0] plen);
		logic [31:0] w;
		w = {ZERO16, plen};
		w[FLAG_FIRST] = first;
		w[FLAG_LAST] = last;
		w[FLAG_OWN] = own;
		w[FLAG_QEND] = qe;
		w[FLAG_CRC_KEPT] = crc;
		w[FLAG_JABBER] = jab;
		return w;
	endfunction

	// Bus side: zero wait states, so the data phase always completes at once.
	wire ahb_take   = hsel & hready & htrans[1];
	wire wr_ctrl    = a_wr & (a_addr == REG_CTRL);
	wire wr_head    = a_wr & (a_addr == REG_HEAD);
	wire wr_offset  = a_wr & (a_addr == REG_OFFSET);
	wire sw_start   = wr_ctrl & hwdata[CTRL_START];
	wire sw_tdown   = wr_ctrl & hwdata[CTRL_TEARDOWN];
	wire running    = (state != ST_HALTED);
	wire [31:0] ctrl_rd = {29'h0, keep_err, tdown_req, 1'b0};
	wire [31:0] stat_rd = {29'h0, tdown_done, qend, running};
	wire [31:0] rd_mux =
		(haddr[7:0] == REG_CTRL)   ? ctrl_rd :
		(haddr[7:0] == REG_HEAD)   ? head :
		(haddr[7:0] == REG_OFFSET) ? {ZERO16, offset_setting} :
		(haddr[7:0] == REG_STATUS) ? stat_rd :
		(haddr[7:0] == REG_CUR)    ? cur : 32'h0000_0000;

	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_wr <= 1'b0;
			a_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else if (ce) begin
			a_wr <= ahb_take & hwrite;
			a_addr <= haddr[7:0];
			if (ahb_take & !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Datapath decodes.
	wire         mem_done   = mem_req & mem_ack;
	wire         link_zero  = (mem_rdata == NULL_LINK);
	wire [15:0]  first_off  = is_first ? offset_setting : ZERO16;
	wire [15:0]  count_inc  = count + ONE16;
	wire         buf_full   = (count_inc == (buf_len - first_off));
	wire [31:0]  byte_addr  = buf_ptr + {ZERO16, first_off} + {ZERO16, count};
	wire         pkt_end    = last_seen | link_zero;
	wire         link_null  = (link == NULL_LINK);
	wire         start_pkt  = (state == ST_IDLE) & !tdown_req & (head != NULL_LINK) & rx_valid;

	assign rx_ready = (state == ST_WAIT) | (state == ST_DRAIN);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (tdown_req && head != NULL_LINK) begin
					next_state = ST_TEARDOWN;
				end else if (tdown_req || head == NULL_LINK) begin
					next_state = ST_HALTED;
				end else if (rx_valid) begin
					next_state = (rx_jabber & !keep_err) ? ST_DRAIN : ST_RD_BUF;
				end
			end
			ST_RD_BUF: if (mem_done) begin
				next_state = ST_RD_LEN;
			end
			ST_RD_LEN: if (mem_done) begin
				next_state = ST_WAIT;
			end
			ST_WAIT: if (rx_valid) begin
				next_state = ST_WR_BYTE;
			end
			ST_WR_BYTE: if (mem_done) begin
				next_state = (last_seen | buf_full) ? ST_WB_LEN : ST_WAIT;
			end
			ST_WB_LEN: if (mem_done) begin
				next_state = ST_RD_NEXT;
			end
			ST_RD_NEXT: if (mem_done) begin
				if (!pkt_end) begin
					next_state = ST_RD_BUF;
				end else begin
					next_state = is_first ? ST_WB_FIRST : ST_WB_FLAGS;
				end
			end
			ST_WB_FLAGS: if (mem_done) begin
				next_state = ST_WB_FIRST;
			end
			ST_WB_FIRST: if (mem_done) begin
				next_state = last_seen ? ST_IDLE : ST_DRAIN;
			end
			ST_DRAIN: if (rx_valid & rx_last) begin
				next_state = ST_IDLE;
			end
			ST_TEARDOWN: if (mem_done) begin
				next_state = ST_HALTED;
			end
			ST_HALTED: if (sw_start) begin
				next_state = ST_IDLE;
			end
			default: next_state = ST_HALTED;
		endcase
	end

	// Memory request. Link and buffer address words are only ever read.
	// no link or pointer writes
	assign mem_req = (state == ST_RD_BUF) | (state == ST_RD_LEN) | (state == ST_WR_BYTE) |
		(state == ST_WB_LEN) | (state == ST_RD_NEXT) | (state == ST_WB_FLAGS) |
		(state == ST_WB_FIRST) | (state == ST_TEARDOWN);
	assign mem_we = (state == ST_WR_BYTE) | (state == ST_WB_LEN) | (state == ST_WB_FLAGS) |
		(state == ST_WB_FIRST) | (state == ST_TEARDOWN);
	assign mem_be = (state == ST_WR_BYTE) ? (BE_BYTE0 << byte_addr[1:0]) : BE_WORD;

	always_comb begin
		mem_addr = cur + DESC_FLAGS;
		mem_wdata = 32'h0000_0000;
		unique case (state)
			ST_RD_BUF: mem_addr = cur + DESC_BUF;
			ST_RD_LEN: mem_addr = cur + DESC_LEN;
			ST_WR_BYTE: begin
				mem_addr = byte_addr;
				mem_wdata = {4{byte_q}};
			end
			ST_WB_LEN: begin
				mem_addr = cur + DESC_LEN;
				mem_wdata = {first_off, count};
			end
			ST_RD_NEXT: mem_addr = cur + DESC_LINK;
			ST_WB_FLAGS: begin
				mem_wdata = flag_word(1'b0, 1'b1, 1'b1, link_null, 1'b0, 1'b0, ZERO16);
			end
			ST_WB_FIRST: begin
				mem_addr = first_addr + DESC_FLAGS;
				mem_wdata = flag_word(1'b1, is_first, 1'b0, is_first & link_null,
					crc_kept, jabber, pkt_len);
			end
			ST_TEARDOWN: begin
				mem_addr = head + DESC_FLAGS;
				mem_wdata[FLAG_TDOWN] = 1'b1;
			end
			default: mem_addr = cur + DESC_FLAGS;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_HALTED;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// Control and status; a hardware set wins over a same-cycle software clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			keep_err <= 1'b0;
			offset_setting <= ZERO16;
			tdown_req <= 1'b0;
			qend <= 1'b0;
			tdown_done <= 1'b0;
		end else if (ce) begin
			if (wr_ctrl) begin
				keep_err <= hwdata[CTRL_KEEP_ERR];
			end
			if (wr_offset) begin
				offset_setting <= hwdata[15:0];
			end
			if (sw_start) begin
				qend <= 1'b0;
				tdown_done <= 1'b0;
			end
			if (sw_tdown) begin
				tdown_req <= 1'b1;
			end
			if (state == ST_IDLE && next_state == ST_HALTED && !tdown_req) begin
				qend <= 1'b1;
			end
			if ((state == ST_TEARDOWN && mem_done) ||
					(tdown_req && (state == ST_HALTED || next_state == ST_HALTED))) begin
				tdown_done <= 1'b1;
				tdown_req <= 1'b0;
			end
		end
	end

	// Queue head: software loads it while halted, hardware advances it per packet.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			head <= NULL_LINK;
		end else if (ce) begin
			if (wr_head && state == ST_HALTED) begin
				head <= hwdata;
			end else if (state == ST_WB_FIRST && mem_done) begin
				head <= link;
			end
		end
	end

	// Packet and descriptor tracking.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur <= NULL_LINK;
			first_addr <= NULL_LINK;
			link <= NULL_LINK;
			buf_ptr <= 32'h0000_0000;
			buf_len <= ZERO16;
			count <= ZERO16;
			pkt_len <= ZERO16;
			byte_q <= 8'h00;
			is_first <= 1'b0;
			last_seen <= 1'b0;
			crc_kept <= 1'b0;
			jabber <= 1'b0;
		end else if (ce) begin
			if (start_pkt) begin
				cur <= head;
				first_addr <= head;
				is_first <= 1'b1;
				last_seen <= 1'b0;
				pkt_len <= ZERO16;
				crc_kept <= rx_crc_present;
				jabber <= rx_jabber;
			end
			if (state == ST_RD_BUF && mem_done) begin
				buf_ptr <= mem_rdata;
			end
			if (state == ST_RD_LEN && mem_done) begin
				buf_len <= mem_rdata[15:0];
				count <= ZERO16;
			end
			if (state == ST_WAIT && rx_valid) begin
				byte_q <= rx_data;
				last_seen <= rx_last;
			end
			if (state == ST_WR_BYTE && mem_done) begin
				count <= count_inc;
				pkt_len <= pkt_len + ONE16;
			end
			if (state == ST_RD_NEXT && mem_done) begin
				link <= mem_rdata;
				if (!pkt_end) begin
					cur <= mem_rdata;
					is_first <= 1'b0;
				end
			end
		end
	end

endmodule

// ### tb.sv
// Bench: random packets through a descriptor chain, then queue end and teardown.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rx_desc_pkg::*;
	localparam int          NDSC = 16;
	localparam logic [15:0] BL   = 16'h18;
	localparam logic [15:0] OFS  = 16'h3;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, rx_valid = 1'h0;
	logic rx_last = 1'h0, rx_jabber = 1'h0, rx_crc_present = 1'h0;
	logic mem_req, mem_we, mem_ack, rx_ready, hreadyout;
	logic [1:0]  htrans = 2'h0, hresp;
	logic [2:0]  hsize = 3'h2;
	logic [7:0]  rx_data = 8'h0, pk [0:511];
	logic [3:0]  mem_be;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mem_addr, mem_wdata, mem_rdata, q;
	int          seed = 32'h637a, n_fail = 0, n_tests = 0, cur = 0;

	rx_descriptor_queue_handler dut (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .rx_jabber(rx_jabber),
		.rx_crc_present(rx_crc_present), .rx_ready(rx_ready));
	mem_model mem (.clk(hclk), .req(mem_req), .we(mem_we), .addr(mem_addr), .be(mem_be),
		.wdata(mem_wdata), .rdata(mem_rdata), .ack(mem_ack));

	initial begin
		forever #25 hclk = ~hclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		q = hrdata;
	endtask

	task automatic put(input int i, input logic [31:0] link);
		mem.m[64+4*i] = link;
		mem.m[65+4*i] = 32'h400 + 32 * i;
		mem.m[66+4*i] = {16'h0, BL};
		mem.m[67+4*i] = 32'h1 << FLAG_OWN;
	endtask

	task automatic send(input int len, input logic jab, input logic crc);
		for (int k = 0; k < len; k++) begin
			pk[k] = 8'($random(seed));
			rx_valid <= 1'h1;
			rx_data <= pk[k];
			rx_last <= k == len - 1;
			rx_jabber <= jab;
			rx_crc_present <= crc;
			@(negedge hclk);
			while (!rx_ready) @(negedge hclk);
			@(posedge hclk);
		end
		rx_valid <= 1'h0;
		rx_last <= 1'h0;
	endtask

	task automatic pkt(input int len, input logic jab, input logic crc);
		int fst, nb, rem, c, o, t;
		logic [31:0] e;
		fst = cur;
		send(len, jab, crc);
		t = 0;
		while (mem.m[67+4*fst][FLAG_OWN] && t < 3000) begin
			@(posedge hclk);
			t++;
		end
		rem = len;
		o = 0;
		for (nb = 0; rem > 0; nb++) begin
			c = (nb == 0) ? BL - OFS : BL;
			if (rem < c) c = rem;
			chk(mem.m[64+4*cur], cur == NDSC - 1 ? 32'h0 : 32'h110 + 16 * cur);
			chk(mem.m[66+4*cur], {nb == 0 ? OFS : 16'h0, 16'(c)});
			for (int j = 0; j < c; j++) begin
				t = (nb == 0 ? OFS : 0) + j;
				chk(mem.m[256+8*cur+t/4][8*(t%4)+:8], pk[o+j]);
			end
			o += c;
			rem -= c;
			cur++;
		end
		e = len;
		e[FLAG_FIRST] = 1'h1;
		e[FLAG_LAST] = nb == 1;
		e[FLAG_QEND] = nb == 1 && cur == NDSC;
		e[FLAG_CRC_KEPT] = crc;
		e[FLAG_JABBER] = jab;
		chk(mem.m[67+4*fst], e);
		if (nb > 1) chk(mem.m[63+4*cur][31:28], {3'h3, cur == NDSC});
		$display("packet of %0d bytes in %0d buffers done", len, nb);
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		n_fail++;
		stop_test;
	end

	initial begin
		int t;
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
		for (int i = 0; i < NDSC; i++) put(i, i == NDSC - 1 ? 32'h0 : 32'h110 + 16 * i);
		@(posedge hclk);
		bus(1'h1, REG_HEAD, 32'h100);
		bus(1'h0, REG_HEAD, 32'h0);
		chk(q, 32'h100);
		chk(hresp, HRESP_OKAY);
		bus(1'h1, REG_OFFSET, {16'h0, OFS});
		bus(1'h1, REG_CTRL, (32'h1 << CTRL_START) | (32'h1 << CTRL_KEEP_ERR));
		bus(1'h0, 8'h40, 32'h0);
		chk(q, 32'h0);
		bus(1'h0, REG_STATUS, 32'h0);
		chk(q[2:0], 3'h1);
		pkt(BL - OFS, 1'h0, 1'h1);
		pkt(BL - OFS + 1, 1'h1, 1'h0);
		repeat (3) pkt(1 + {$random(seed)} % 40, 1'($random(seed)), 1'($random(seed)));
		bus(1'h1, REG_CTRL, 32'h0);
		send(5, 1'h1, 1'h0);
		bus(1'h1, REG_CTRL, 32'h1 << CTRL_KEEP_ERR);
		bus(1'h0, REG_CTRL, 32'h0);
		chk(q[2:0], 3'h4);
		chk(mem.m[67+4*cur], 32'h1 << FLAG_OWN);
		chk(mem.m[66+4*cur], {16'h0, BL});
		$display("dropped jabber packet done");
		pkt(BL - OFS + BL * (NDSC - cur - 1), 1'h1, 1'h1);
		// The channel halts a few cycles after the hardware_owns_flag flag clears, so poll for it.
		q = 32'h1;
		for (t = 0; t < 20 && q[ST_RUNNING]; t++) bus(1'h0, REG_STATUS, 32'h0);
		chk(q[2:0], 3'h2);
		put(16, 32'h0);
		mem.m[124] = 32'h200;
		bus(1'h1, REG_HEAD, 32'h200);
		bus(1'h1, REG_CTRL, 32'h1 << CTRL_START);
		bus(1'h1, REG_CTRL, 32'h1 << CTRL_TEARDOWN);
		for (t = 0; t < 200 && !q[ST_TDOWN_DONE]; t++) bus(1'h0, REG_STATUS, 32'h0);
		chk(q[ST_TDOWN_DONE], 1'h1);
		chk(mem.m[131][FLAG_TDOWN], 1'h1);
		$display("teardown done");
		stop_test;
	end
endmodule
